// ==== design/stepper_pulse_profiler.sv ====
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module stepper_pulse_profiler #(
    parameter int TICK_CYCLES = motion_pkg::TICK_CYCLES
) (
    // Clock, reset and clock enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Step and select lines
    output logic step,
    output logic dir,
    output logic microstep_sel_lo,
    output logic microstep_sel_hi,
    // Static control lines
    output logic drive_en_low,
    output logic doze_bar,
    output logic clear_bar,
    output logic sync_rectify_bar,
    // Serial control words
    output logic ser_clk,
    output logic ser_data,
    output logic ser_latch,
    output logic ser_chan,
    // Reference codes
    output logic [11:0] first_pair_reference,
    output logic [11:0] second_pair_reference
);
    logic [7:0] ctrl_r;
    logic [15:0] target_r, count_r, word_a_r, word_b_r;
    logic [7:0] accel_r, tbase_r;
    logic [11:0] ref_a_r, ref_b_r;
    logic [15:0] rate_r, goal_r, left_r, rdata_r;
    logic [15:0] rate_nxt;
    motion_pkg::mode_type mode_r;
    logic [31:0] tick_cnt_r;
    logic [7:0] tb_cnt_r;
    logic [2:0] sel_r;
    logic pend_a_r, pend_b_r, chan_r;
    logic [15:0] cmd;
    logic ready_ok, run, step_rise, step_fall, ms_tick, upd_tick, at_floor;
    logic launch, ser_busy, set_a, set_b;
    logic [16:0] up_sum;

    function automatic logic wr_hit(input logic [3:0] off);
        return reg_wr && reg_addr == off;
    endfunction

    function automatic logic [15:0] clamp_rate(input logic [15:0] v);
        return (v < motion_pkg::MIN_RATE) ? motion_pkg::MIN_RATE : v;
    endfunction

    assign cmd = wr_hit(motion_pkg::OFF_CMD) ? reg_wdata : 16'h0000;
    assign ready_ok = !ctrl_r[motion_pkg::CB_EN_LOW] &&
        ctrl_r[motion_pkg::CB_DOZE] && ctrl_r[motion_pkg::CB_CLEAR];
    assign run = mode_r != motion_pkg::ST_IDLE;
    assign at_floor = rate_r <= motion_pkg::MIN_RATE || accel_r == 8'h00;

    // Software registers.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= motion_pkg::CTRL_RESET;
            target_r <= 16'h0000;
            accel_r <= 8'h00;
            tbase_r <= 8'h00;
            count_r <= 16'h0000;
            word_a_r <= 16'h0000;
            word_b_r <= 16'h0000;
            ref_a_r <= 12'h000;
            ref_b_r <= 12'h000;
        end else if (ce) begin
            if (wr_hit(motion_pkg::OFF_CTRL)) ctrl_r <= reg_wdata[7:0];
            if (wr_hit(motion_pkg::OFF_TARGET)) target_r <= reg_wdata;
            if (wr_hit(motion_pkg::OFF_ACCEL)) accel_r <= reg_wdata[7:0];
            if (wr_hit(motion_pkg::OFF_TBASE)) tbase_r <= reg_wdata[7:0];
            if (wr_hit(motion_pkg::OFF_COUNT)) count_r <= reg_wdata;
            if (wr_hit(motion_pkg::OFF_WORD_A)) word_a_r <= reg_wdata;
            if (wr_hit(motion_pkg::OFF_WORD_B)) word_b_r <= reg_wdata;
            if (wr_hit(motion_pkg::OFF_REF_A)) ref_a_r <= reg_wdata[11:0];
            if (wr_hit(motion_pkg::OFF_REF_B)) ref_b_r <= reg_wdata[11:0];
        end
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
        end else if (ce) begin
            rdata_r <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    motion_pkg::OFF_CTRL: rdata_r <= {8'h00, ctrl_r};
                    motion_pkg::OFF_TARGET: rdata_r <= target_r;
                    motion_pkg::OFF_ACCEL: rdata_r <= {8'h00, accel_r};
                    motion_pkg::OFF_TBASE: rdata_r <= {8'h00, tbase_r};
                    motion_pkg::OFF_COUNT: rdata_r <= count_r;
                    motion_pkg::OFF_WORD_A: rdata_r <= word_a_r;
                    motion_pkg::OFF_WORD_B: rdata_r <= word_b_r;
                    motion_pkg::OFF_REF_A: rdata_r <= {4'h0, ref_a_r};
                    motion_pkg::OFF_REF_B: rdata_r <= {4'h0, ref_b_r};
                    motion_pkg::OFF_STATUS: rdata_r <= {9'h000, pend_b_r,
                        pend_a_r, ser_busy, ready_ok, step, 2'(mode_r)};
                    motion_pkg::OFF_RATE: rdata_r <= rate_r;
                    motion_pkg::OFF_LEFT: rdata_r <= left_r;
                    default: rdata_r <= 16'h0000;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_r;

    // Millisecond tick and time base; both restart whenever the motor halts.
    assign ms_tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
    assign upd_tick = ms_tick && tb_cnt_r >= tbase_r;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_r <= 32'h00000000;
            tb_cnt_r <= 8'h00;
        end else if (ce) begin
            if (!run || ms_tick) tick_cnt_r <= 32'h00000000;
            else tick_cnt_r <= tick_cnt_r + 32'h00000001;
            if (!run || upd_tick) tb_cnt_r <= 8'h00;
            else if (ms_tick) tb_cnt_r <= tb_cnt_r + 8'h01;
        end
    end

    // Rate moves toward the goal, or toward the minimum rate while stopping, by the increment, never past it.
    assign up_sum = {1'b0, rate_r} + {9'h000, accel_r};
    always_comb begin
        rate_nxt = rate_r;
        if (mode_r == motion_pkg::ST_DECEL) begin
            rate_nxt = (rate_r > 16'(accel_r) + motion_pkg::MIN_RATE) ?
                rate_r - 16'(accel_r) : motion_pkg::MIN_RATE;
        end else if (rate_r < goal_r) begin
            rate_nxt = (up_sum >= {1'b0, goal_r}) ? goal_r : up_sum[15:0];
        end else if (rate_r > goal_r) begin
            rate_nxt = ({1'b0, rate_r} > {1'b0, goal_r} + 17'(accel_r)) ?
                rate_r - 16'(accel_r) : goal_r;
        end
    end

    // Motion sequencing; stop takes priority over start, pulse and move; in RUN an update in the same write as a stop still loads the goal.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= motion_pkg::ST_IDLE;
            rate_r <= motion_pkg::MIN_RATE;
            goal_r <= motion_pkg::MIN_RATE;
            left_r <= 16'h0000;
        end else if (ce) begin
            unique case (mode_r)
                motion_pkg::ST_IDLE: begin
                    if (cmd[motion_pkg::CMD_STOP] || !ready_ok) begin
                        mode_r <= motion_pkg::ST_IDLE;
                    end else if (cmd[motion_pkg::CMD_START]) begin
                        mode_r <= motion_pkg::ST_RUN;
                        rate_r <= motion_pkg::MIN_RATE;
                        goal_r <= clamp_rate(target_r);
                    end else if (cmd[motion_pkg::CMD_PULSE]) begin
                        mode_r <= motion_pkg::ST_COUNT;
                        rate_r <= clamp_rate(target_r);
                        left_r <= 16'h0001;
                    end else if (cmd[motion_pkg::CMD_MOVE] &&
                                 count_r != 16'h0000) begin
                        mode_r <= motion_pkg::ST_COUNT;
                        rate_r <= clamp_rate(target_r);
                        left_r <= count_r;
                    end
                end
                motion_pkg::ST_RUN: begin
                    if (cmd[motion_pkg::CMD_STOP]) begin
                        mode_r <= motion_pkg::ST_DECEL;
                    end else if (upd_tick) begin
                        rate_r <= rate_nxt;
                    end
                    if (cmd[motion_pkg::CMD_UPDATE]) goal_r <= clamp_rate(target_r);
                end
                motion_pkg::ST_DECEL: begin
                    if (at_floor && step_fall) mode_r <= motion_pkg::ST_IDLE;
                    else if (upd_tick) rate_r <= rate_nxt;
                end
                motion_pkg::ST_COUNT: begin
                    if (step_rise) left_r <= left_r - 16'h0001;
                    if (cmd[motion_pkg::CMD_STOP] ||
                        (step_fall && left_r == 16'h0000)) begin
                        mode_r <= motion_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // rising edge per step, half-period high time
    step_timer u_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .run(run),
        .rate(rate_r),
        .step_r(step),
        .rise(step_rise),
        .fall(step_fall)
    );

    // selects move only while step stays low
    // Holding them on a rising edge gives the driver a cycle of setup.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) sel_r <= 3'h0;
        else if (ce && !step && !step_rise)
            sel_r <= ctrl_r[motion_pkg::CB_MS_HI:motion_pkg::CB_DIR];
    end
    assign dir = sel_r[0];
    assign microstep_sel_lo = sel_r[1];
    assign microstep_sel_hi = sel_r[2];
    // bit level is line level, rectification low after reset
    assign drive_en_low = ctrl_r[motion_pkg::CB_EN_LOW];
    assign doze_bar = ctrl_r[motion_pkg::CB_DOZE];
    assign clear_bar = ctrl_r[motion_pkg::CB_CLEAR];
    assign sync_rectify_bar = ctrl_r[motion_pkg::CB_SR];
    assign first_pair_reference = ref_a_r;
    assign second_pair_reference = ref_b_r;

    // pending words; a new request beats the clear of the old one
    assign set_a = cmd[motion_pkg::CMD_SEND_A] ||
        (wr_hit(motion_pkg::OFF_WORD_A) && ctrl_r[motion_pkg::CB_AUTO] &&
         reg_wdata != word_a_r);
    assign set_b = cmd[motion_pkg::CMD_SEND_B] ||
        (wr_hit(motion_pkg::OFF_WORD_B) && ctrl_r[motion_pkg::CB_AUTO] &&
         reg_wdata != word_b_r);
    assign launch = !ser_busy && (pend_a_r || pend_b_r);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_a_r <= 1'b0;
            pend_b_r <= 1'b0;
            chan_r <= 1'b0;
        end else if (ce) begin
            pend_a_r <= set_a || (pend_a_r && !launch);
            pend_b_r <= set_b || (pend_b_r && !(launch && !pend_a_r));
            if (launch) chan_r <= !pend_a_r;
        end
    end
    assign ser_chan = chan_r;

    word_sender u_sender (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .start(ce && launch),
        .word(pend_a_r ? word_a_r : word_b_r),
        .busy_r(ser_busy),
        .ser_clk_r(ser_clk),
        .ser_data(ser_data),
        .ser_latch_r(ser_latch)
    );

    sequence start_taken;
        ce && mode_r == motion_pkg::ST_IDLE && ready_ok &&
            cmd[motion_pkg::CMD_START] && !cmd[motion_pkg::CMD_STOP];
    endsequence
    sequence pulse_taken;
        ce && mode_r == motion_pkg::ST_IDLE && ready_ok &&
            cmd[15:0] == 16'h0004;
    endsequence

    chk_start_rate: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        start_taken |=> rate_r == motion_pkg::MIN_RATE &&
            mode_r == motion_pkg::ST_RUN)
        else $error("start did not begin at the lowest rate");
    chk_ramp_add: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && mode_r == motion_pkg::ST_RUN && !cmd[motion_pkg::CMD_STOP] &&
            upd_tick && up_sum < {1'b0, goal_r}
        |=> rate_r == $past(rate_r) + 16'($past(accel_r)))
        else $error("ramp did not add the increment");
    chk_rate_spacing: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && run && !upd_tick && mode_r != motion_pkg::ST_COUNT
        && $past(mode_r) == mode_r |=> rate_r == $past(rate_r))
        else $error("rate changed between updates");
    chk_goal_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && mode_r == motion_pkg::ST_RUN && rate_r == goal_r &&
            !cmd[motion_pkg::CMD_UPDATE] |=> rate_r == $past(goal_r))
        else $error("rate left the target");
    chk_decel_step: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && mode_r == motion_pkg::ST_DECEL && upd_tick && !at_floor
        |=> rate_r < $past(rate_r))
        else $error("stop did not slow the rate");
    chk_rise_low: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(step) |-> $past(step_rise))
        else $error("step rose without a timed edge");
    chk_idle_quiet: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        mode_r == motion_pkg::ST_IDLE && $past(mode_r) == motion_pkg::ST_IDLE
        |-> !step)
        else $error("step high while halted");
    chk_goal_idle: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && mode_r == motion_pkg::ST_IDLE &&
            !(ready_ok && cmd[motion_pkg::CMD_START] &&
              !cmd[motion_pkg::CMD_STOP])
        |=> goal_r == $past(goal_r))
        else $error("target taken while halted");
    chk_one_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        pulse_taken |=> left_r == 16'h0001 ##0
            (mode_r == motion_pkg::ST_COUNT) [*1] ##0 !step)
        else $error("single pulse not armed for one step");
    chk_move_done: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        step_fall && mode_r == motion_pkg::ST_COUNT && left_r == 16'h0000
        |=> mode_r == motion_pkg::ST_IDLE && !step)
        else $error("counted move did not stop");
    chk_start_ready: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && mode_r == motion_pkg::ST_IDLE && !ready_ok
        |=> mode_r == motion_pkg::ST_IDLE)
        else $error("stepping began with lines not ready");
    chk_sel_steady: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        step |-> $stable(sel_r))
        else $error("select moved while step high");
    chk_auto_send: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && set_a |=> pend_a_r)
        else $error("word change not queued");
endmodule

// ==== design/motion_pkg.sv ====
package motion_pkg;
    // Clock and time base.
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam logic [26:0] STEP_HALF = 27'(CLK_HZ / 2);
    localparam int SER_HALF_NS = 50;
    localparam int SER_HALF_CYCLES = SER_HALF_NS / CLK_PERIOD_NS;

    // Rate limits in pulses per second.
    localparam logic [15:0] MIN_RATE = 16'h003E;

    // Register offsets.
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_TARGET = 4'h1;
    localparam logic [3:0] OFF_ACCEL = 4'h2;
    localparam logic [3:0] OFF_TBASE = 4'h3;
    localparam logic [3:0] OFF_COUNT = 4'h4;
    localparam logic [3:0] OFF_CMD = 4'h5;
    localparam logic [3:0] OFF_WORD_A = 4'h6;
    localparam logic [3:0] OFF_WORD_B = 4'h7;
    localparam logic [3:0] OFF_REF_A = 4'h8;
    localparam logic [3:0] OFF_REF_B = 4'h9;
    localparam logic [3:0] OFF_STATUS = 4'hA;
    localparam logic [3:0] OFF_RATE = 4'hB;
    localparam logic [3:0] OFF_LEFT = 4'hC;

    // Control register fields.
    localparam int CB_EN_LOW = 0;
    localparam int CB_DOZE = 1;
    localparam int CB_CLEAR = 2;
    localparam int CB_DIR = 3;
    localparam int CB_MS_LO = 4;
    localparam int CB_MS_HI = 5;
    localparam int CB_SR = 6;
    localparam int CB_AUTO = 7;
    localparam logic [7:0] CTRL_RESET = 8'h01;

    // Command register fields, write only.
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_PULSE = 2;
    localparam int CMD_MOVE = 3;
    localparam int CMD_UPDATE = 4;
    localparam int CMD_SEND_A = 5;
    localparam int CMD_SEND_B = 6;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_COUNT} mode_type;
endpackage

// ==== design/step_timer.sv ====
`timescale 1ns/1ps
module step_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Rate control
    input wire logic run,
    input wire logic [15:0] rate,
    // Step line and its edges
    output logic step_r,
    output logic rise,
    output logic fall
);
    logic [26:0] acc_r;
    logic [26:0] sum;
    logic wrap;

    // The accumulator crosses half a second of pulses twice per step, so the
    // line is high for half the period at any rate.
    assign sum = acc_r + {11'h000, rate};
    assign wrap = sum >= motion_pkg::STEP_HALF;
    assign rise = ce & run & wrap & ~step_r;
    assign fall = ce & run & wrap & step_r;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= 27'h0000000;
            step_r <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                acc_r <= 27'h0000000;
                step_r <= 1'b0;
            end else if (wrap) begin
                acc_r <= sum - motion_pkg::STEP_HALF;
                step_r <= ~step_r;
            end else begin
                acc_r <= sum;
            end
        end
    end
endmodule

// ==== design/word_sender.sv ====
`timescale 1ns/1ps
module word_sender #(
    parameter int HALF_CYCLES = motion_pkg::SER_HALF_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Launch
    input wire logic start,
    input wire logic [15:0] word,
    output logic busy_r,
    // Serial lines
    output logic ser_clk_r,
    output logic ser_data,
    output logic ser_latch_r
);
    logic [15:0] sh_r;
    logic [4:0] bits_r;
    logic [7:0] div_r;
    logic half_done;

    assign half_done = div_r == 8'(HALF_CYCLES - 1);
    assign ser_data = sh_r[15];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
            sh_r <= 16'h0000;
            bits_r <= 5'h00;
            div_r <= 8'h00;
            ser_clk_r <= 1'b0;
            ser_latch_r <= 1'b0;
        end else if (ce) begin
            ser_latch_r <= 1'b0;
            if (!busy_r) begin
                if (start) begin
                    busy_r <= 1'b1;
                    sh_r <= word;
                    bits_r <= 5'h00;
                    div_r <= 8'h00;
                end
            end else if (!half_done) begin
                div_r <= div_r + 8'h01;
            end else begin
                div_r <= 8'h00;
                ser_clk_r <= ~ser_clk_r;
                // The driver samples on the rising edge; shift on the fall.
                if (ser_clk_r) begin
                    sh_r <= {sh_r[14:0], 1'b0};
                    bits_r <= bits_r + 5'h01;
                    if (bits_r == 5'h0F) begin
                        busy_r <= 1'b0;
                        ser_latch_r <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ==== sim/driver_model.sv ====
`timescale 1ns/1ps
module driver_model (
    // Step side
    input wire logic ref_clk,
    input wire logic step,
    input wire logic dir,
    // Serial side
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    input wire logic ser_chan,
    // What the driver saw
    output int rises,
    output int high_len,
    output int slips,
    output logic [16:0] got
);
    int run_len;
    logic [15:0] sh;
    logic step_q, dir_q, clk_q;
    initial begin
        rises = 0;
        slips = 0;
        high_len = 0;
        run_len = 0;
        got = 17'h00000;
    end
    always @(posedge ref_clk) begin
        step_q <= step;
        dir_q <= dir;
        clk_q <= ser_clk;
        if (step && !step_q) rises <= rises + 1;
        run_len <= step ? run_len + 1 : 0;
        if (!step && step_q) high_len <= run_len;
        if (step && dir !== dir_q) slips <= slips + 1;
        if (ser_clk && !clk_q) sh <= {sh[14:0], ser_data};
        if (ser_latch) got <= {ser_chan, sh};
    end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, \
    (g), (e)); end end
module tb;
    localparam logic [15:0] TOP = 16'hFF3E;
    logic ref_clk, rst_b, reg_wr, reg_rd, ce;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic step, dir, sel_lo, sel_hi, en_low, doze, clr, sr;
    logic ser_clk, ser_data, ser_latch, ser_chan;
    logic [11:0] ref_a, ref_b;
    logic [16:0] got;
    int bad_count, checks_done, rises, high_len, slips, n0;

    stepper_pulse_profiler #(.TICK_CYCLES(20)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step(step), .dir(dir),
        .microstep_sel_lo(sel_lo), .microstep_sel_hi(sel_hi),
        .drive_en_low(en_low), .doze_bar(doze), .clear_bar(clr),
        .sync_rectify_bar(sr), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_latch(ser_latch), .ser_chan(ser_chan),
        .first_pair_reference(ref_a), .second_pair_reference(ref_b));
    driver_model peer (
        .ref_clk(ref_clk), .step(step), .dir(dir), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_latch(ser_latch), .ser_chan(ser_chan),
        .rises(rises), .high_len(high_len), .slips(slips), .got(got));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Polls the mode field; a run that never halts ends the test here.
    task automatic idle_wait(input int lim);
        for (int i = 0; i < lim; i++) begin
            rd(motion_pkg::OFF_STATUS);
            if (d[1:0] === 2'h0) return;
        end
        bad_count++;
        wrap_up();
    endtask

    task automatic ser_wait(input logic [16:0] v);
        for (int i = 0; i < 400 && got !== v; i++) @(posedge ref_clk);
        `CHK(got, v)
    endtask

    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ce = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        bad_count = 0;
        checks_done = 0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1 `CHK({sr, clr, doze, en_low}, 4'h1)
        rd(motion_pkg::OFF_CTRL);
        `CHK(d, 16'h0001)
        wr(motion_pkg::OFF_CMD, 16'h0001);
        rd(motion_pkg::OFF_STATUS);
        `CHK(d[1:0], 2'h0)
        rd(4'hF);
        `CHK(d, 16'h0000)
        wr(motion_pkg::OFF_CTRL, 16'h0046);
        `CHK({sr, clr, doze, en_low}, 4'hE)
        wr(motion_pkg::OFF_CTRL, 16'h0006);
        `CHK(sr, 1'b0)
        wr(motion_pkg::OFF_REF_A, 16'h0FFF);
        wr(motion_pkg::OFF_REF_B, 16'h0123);
        // A frozen block must ignore this write.
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(motion_pkg::OFF_REF_B, 16'h0456);
        @(posedge ref_clk);
        ce <= 1'b1;
        @(posedge ref_clk);
        #1 `CHK({ref_a, ref_b}, 24'hFFF123)
        $display("done: control lines");
        wr(motion_pkg::OFF_CTRL, 16'h0086);
        wr(motion_pkg::OFF_WORD_A, 16'hA5C3);
        ser_wait(17'h0A5C3);
        wr(motion_pkg::OFF_CTRL, 16'h0006);
        wr(motion_pkg::OFF_WORD_B, 16'h3C5A);
        repeat (300) @(posedge ref_clk);
        `CHK(got, 17'h0A5C3)
        wr(motion_pkg::OFF_CMD, 16'h0040);
        ser_wait(17'h13C5A);
        $display("done: serial words");
        wr(motion_pkg::OFF_TARGET, TOP);
        wr(motion_pkg::OFF_ACCEL, 16'h00FF);
        wr(motion_pkg::OFF_TBASE, 16'h0000);
        wr(motion_pkg::OFF_CMD, 16'h0010);
        rd(motion_pkg::OFF_STATUS);
        `CHK(d[1:0], 2'h0)
        wr(motion_pkg::OFF_CMD, 16'h0001);
        rd(motion_pkg::OFF_RATE);
        `CHK(d, motion_pkg::MIN_RATE)
        n0 = 0;
        for (int i = 0; i < 4000 && d !== TOP; i++) begin
            rd(motion_pkg::OFF_RATE);
            if (d > TOP || (d - 16'd62) % 16'd255 != 0) n0++;
        end
        `CHK(n0, 0)
        `CHK(d, TOP)
        wr(motion_pkg::OFF_CTRL, 16'h003E);
        for (int i = 0; i < 20000 && rises < 4; i++) @(posedge ref_clk);
        rd(motion_pkg::OFF_RATE);
        `CHK(d, TOP)
        `CHK(rises >= 4, 1'b1)
        `CHK(slips, 0)
        `CHK({sel_hi, sel_lo, dir}, 3'h7)
        `CHK(high_len inside {[764:767]}, 1'b1)
        wr(motion_pkg::OFF_CMD, 16'h0002);
        rd(motion_pkg::OFF_STATUS);
        `CHK(d[1:0], 2'h2)
        d = TOP;
        for (int i = 0; i < 100 && d >= TOP; i++) rd(motion_pkg::OFF_RATE);
        `CHK(d, TOP - 16'd255)
        // A zero step ends the slow tail of the ramp early.
        wr(motion_pkg::OFF_ACCEL, 16'h0000);
        idle_wait(3000);
        `CHK(step, 1'b0)
        $display("done: ramped run");
        n0 = rises;
        wr(motion_pkg::OFF_CMD, 16'h0004);
        idle_wait(3000);
        `CHK(rises - n0, 1)
        wr(motion_pkg::OFF_COUNT, 16'h0003);
        n0 = rises;
        wr(motion_pkg::OFF_CMD, 16'h0008);
        rd(motion_pkg::OFF_RATE);
        `CHK(d, TOP)
        idle_wait(5000);
        `CHK(rises - n0, 3)
        $display("done: pulse and move");
        wrap_up();
    end
endmodule
